// >>> rtl/dcf_fifo.sv
// 18-bit FIFO with empty, full, half-full and almost flags plus cascade ring.
// Assumes wr_tick and rd_tick are one-cycle enables from the owners of each side.
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps

// Operation
// - A write tick with write enable low stores the input word.
// - Held write enable stores one word on every write tick.
// - Both data buses and every entry are 18 bits wide.
// - Read side runs on its own tick and enable like the write side.
// - Read and write ticks may coincide or be fully independent.
// - Writes happen only when not full; writes while full are dropped.
// - With load low, a write tick loads the offset register instead.
// - Status outputs encode empty, almost empty, half, almost full, full.
// - Shared pin shows half-full when not cascaded.
// - Shared pin carries the write chain pulse when cascaded.
// - Empty flag changes only on read ticks.
// - Full flag changes only on write ticks.
// - Empty and full come straight from flip-flops, glitch free.
// - Flag mode low makes almost flags follow their side's tick.
// - Chain outputs feed the next device; the last closes the ring.
// - First-load low marks the device that starts the chain.
// - Read tick presents next word if not empty, or offset under load.
// - Empty low when no words; full low when no room left.
// - Output enable low drives the data bus, high releases it.
// - Reset returns the buffer to empty; needed before first use.
module dcf_fifo #(
  parameter int DEPTH = dcf_pkg::DEPTH_DEF
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       reset_n,
  input  wire logic [dcf_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output wire logic                       s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output wire logic                       s_axi_wready,
  output wire logic [1:0]                 s_axi_bresp,
  output wire logic                       s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [dcf_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output wire logic                       s_axi_arready,
  output wire logic [31:0]                s_axi_rdata,
  output wire logic [1:0]                 s_axi_rresp,
  output wire logic                       s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       wr_tick,
  input  wire logic                       wr_en_n,
  input  wire logic [dcf_pkg::DATA_W-1:0] wr_data,
  input  wire logic                       rd_tick,
  input  wire logic                       rd_en_n,
  output wire logic [dcf_pkg::DATA_W-1:0] rd_data,
  output wire logic                       rd_data_oe,
  input  wire logic                       output_en_n,
  input  wire logic                       offset_load_n,
  input  wire logic                       flag_sync_mode_n,
  input  wire logic                       replay_strobe,
  input  wire logic                       chain_first_n,
  input  wire logic                       write_chain_in_n,
  input  wire logic                       read_chain_in_n,
  output wire logic                       write_chain_out_half_full_n,
  output wire logic                       read_chain_out_n,
  output wire logic                       empty_n,
  output wire logic                       full_n,
  output wire logic                       almost_empty_n,
  output wire logic                       almost_full_n
);
  import dcf_pkg::*;

  localparam int              AW       = $clog2(DEPTH);
  localparam int              CW       = AW + 1;
  localparam logic [CW-1:0]   FULL_CNT = CW'(DEPTH);
  localparam logic [CW-1:0]   HALF_CNT = CW'(DEPTH / 2);
  localparam logic [AW-1:0]   LAST_PTR = AW'(DEPTH - 1);

  logic [DATA_W-1:0] mem [DEPTH];
  logic [AW-1:0]     wr_ptr_r;
  logic [AW-1:0]     rd_ptr_r;
  logic [CW-1:0]     count_r;
  logic [CW-1:0]     count_nxt;
  logic [DATA_W-1:0] offset_r;
  logic [DATA_W-1:0] rd_data_r;
  logic              empty_n_r;
  logic              full_n_r;
  logic              ae_n_r;
  logic              af_n_r;
  logic              hf_n_r;
  logic              wr_tok_r;
  logic              rd_tok_r;
  logic              wr_pass_r;
  logic              rd_pass_r;
  logic              rst;
  logic              casc;
  logic              off_wr;
  logic [17:0]       off_wdata;
  logic              wr_hit;
  logic              rd_hit;
  logic              wr_go;
  logic              rd_go;
  logic              ld_wr;
  logic              ld_rd;
  logic              replay;

  function automatic logic ae_hit(input logic [CW-1:0] cnt, input logic [DATA_W-1:0] off);
    ae_hit = (int'(cnt) <= int'(off));
  endfunction

  function automatic logic af_hit(input logic [CW-1:0] cnt, input logic [DATA_W-1:0] off);
    af_hit = (int'(cnt) >= DEPTH - int'(off));
  endfunction

  // ==========================================================
  // Register slave
  dcf_axil u_axil (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .casc          (casc),
    .off_wr        (off_wr),
    .off_wdata     (off_wdata),
    .offset        (offset_r),
    .status        ({25'h0000000, rd_tok_r, wr_tok_r, full_n_r, af_n_r, hf_n_r,
                     ae_n_r, empty_n_r}),
    .level         ({{(32-CW){1'b0}}, count_r})
  );

  // ==========================================================
  // Access qualification
  // Device reset pin and bus reset both empty the buffer
  assign rst    = !aresetn || !reset_n;
  assign replay = replay_strobe && !casc;
  assign wr_hit = wr_tick && !wr_en_n;
  assign rd_hit = rd_tick && !rd_en_n;
  // Gating on the true count, not the lagging flag, keeps overflow impossible
  assign wr_go  = wr_hit && offset_load_n && (count_r != FULL_CNT)
                  && (!casc || wr_tok_r);
  assign rd_go  = rd_hit && offset_load_n && (count_r != '0) && !replay
                  && (!casc || rd_tok_r);
  assign ld_wr  = wr_hit && !offset_load_n;
  assign ld_rd  = rd_hit && !offset_load_n;

  always_comb begin
    if (replay) begin
      count_nxt = CW'(wr_ptr_r) + CW'(wr_go);
    end else begin
      count_nxt = count_r + CW'(wr_go) - CW'(rd_go);
    end
  end

  // ==========================================================
  // Storage and pointers
  always_ff @(posedge aclk) begin
    if (wr_go) begin
      mem[wr_ptr_r] <= wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (wr_go) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (replay) begin
        rd_ptr_r <= '0;
      end else if (rd_go) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r <= count_nxt;
    end
  end

  // Pin load wins over a bus write landing in the same cycle
  always_ff @(posedge aclk) begin
    if (rst) begin
      offset_r <= OFFSET_RST;
    end else if (ld_wr) begin
      offset_r <= wr_data;
    end else if (off_wr) begin
      offset_r <= off_wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      rd_data_r <= '0;
    end else if (ld_rd) begin
      rd_data_r <= offset_r;
    end else if (rd_go) begin
      rd_data_r <= mem[rd_ptr_r];
    end
  end

  // The pad drives only while enabled; the wire itself is resolved outside
  assign rd_data    = rd_data_r;
  assign rd_data_oe = !output_en_n;

  // ==========================================================
  // Flags
  // Empty sees a write only at the next read tick: one tick of latency by design
  always_ff @(posedge aclk) begin
    if (rst) begin
      empty_n_r <= 1'b0;
    end else if (rd_tick) begin
      empty_n_r <= (count_nxt != '0);
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      full_n_r <= 1'b1;
    end else if (wr_tick) begin
      full_n_r <= (count_nxt != FULL_CNT);
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      ae_n_r <= 1'b0;
      af_n_r <= 1'b1;
    end else begin
      if (flag_sync_mode_n || rd_tick) begin
        ae_n_r <= !ae_hit(count_nxt, offset_r);
      end
      if (flag_sync_mode_n || wr_tick) begin
        af_n_r <= !af_hit(count_nxt, offset_r);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      hf_n_r <= 1'b1;
    end else begin
      hf_n_r <= !(count_nxt > HALF_CNT);
    end
  end

  assign empty_n        = empty_n_r;
  assign full_n         = full_n_r;
  assign almost_empty_n = ae_n_r;
  assign almost_full_n  = af_n_r;

  // ==========================================================
  // Cascade ring
  // Each device fills its whole array before handing the write token on
  always_ff @(posedge aclk) begin
    if (rst) begin
      wr_tok_r  <= !chain_first_n;
      rd_tok_r  <= !chain_first_n;
      wr_pass_r <= 1'b0;
      rd_pass_r <= 1'b0;
    end else begin
      wr_pass_r <= casc && wr_go && (wr_ptr_r == LAST_PTR);
      rd_pass_r <= casc && rd_go && (rd_ptr_r == LAST_PTR);
      if (casc && wr_go && (wr_ptr_r == LAST_PTR)) begin
        wr_tok_r <= 1'b0;
      end else if (!write_chain_in_n) begin
        wr_tok_r <= 1'b1;
      end
      if (casc && rd_go && (rd_ptr_r == LAST_PTR)) begin
        rd_tok_r <= 1'b0;
      end else if (!read_chain_in_n) begin
        rd_tok_r <= 1'b1;
      end
    end
  end

  assign write_chain_out_half_full_n = casc ? !wr_pass_r : hf_n_r;
  assign read_chain_out_n            = !rd_pass_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (rst);

  property p_wr_store;
    wr_go |=> mem[$past(wr_ptr_r)] == $past(wr_data);
  endproperty
  a_wr_store: assert property (p_wr_store) else $error("write not stored");

  property p_back_to_back;
    (wr_go && !rd_go && !replay) ##1 (wr_go && !rd_go && !replay)
      |=> count_r == $past(count_r, 2) + CW'(2);
  endproperty
  a_back_to_back: assert property (p_back_to_back) else $error("burst lost a word");

  property p_full_drop;
    (wr_hit && count_r == FULL_CNT && !replay) |=> wr_ptr_r == $past(wr_ptr_r);
  endproperty
  a_full_drop: assert property (p_full_drop) else $error("write while full");

  property p_load_wr;
    ld_wr |=> offset_r == $past(wr_data) && wr_ptr_r == $past(wr_ptr_r);
  endproperty
  a_load_wr: assert property (p_load_wr) else $error("offset load failed");

  property p_empty_step;
    !rd_tick |=> $stable(empty_n);
  endproperty
  a_empty_step: assert property (p_empty_step) else $error("empty moved off tick");

  property p_full_step;
    !wr_tick |=> $stable(full_n);
  endproperty
  a_full_step: assert property (p_full_step) else $error("full moved off tick");

  property p_ae_sync;
    (!flag_sync_mode_n && !rd_tick) |=> $stable(almost_empty_n);
  endproperty
  a_ae_sync: assert property (p_ae_sync) else $error("almost empty not synchronous");

  property p_rd_load;
    ld_rd |=> rd_data == $past(offset_r);
  endproperty
  a_rd_load: assert property (p_rd_load) else $error("offset readback wrong");

  property p_half;
    !casc |-> write_chain_out_half_full_n == !(count_r > HALF_CNT);
  endproperty
  a_half: assert property (p_half) else $error("half full wrong");

  property p_chain_pass;
    (casc && wr_go && wr_ptr_r == LAST_PTR)
      |=> !write_chain_out_half_full_n ##1 write_chain_out_half_full_n || !casc;
  endproperty
  a_chain_pass: assert property (p_chain_pass) else $error("chain pulse wrong");

endmodule

// >>> rtl/dcf_pkg.sv
// Constants shared by the 18-bit flagged FIFO and its register slave.
// Assumes a single aclk domain; read and write rates arrive as tick enables.
package dcf_pkg;

  // ==========================================================
  // Data path
  localparam int DATA_W    = 18;
  localparam int DEPTH_DEF = 8192;

  // ==========================================================
  // Register map (byte addresses, 32-byte window)
  localparam int         AXI_AW     = 5;
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_OFFSET = 5'h04;
  localparam logic [4:0] REG_STATUS = 5'h08;
  localparam logic [4:0] REG_LEVEL  = 5'h0C;

  // ==========================================================
  // Fields and reset values
  localparam int          CTRL_CASC  = 0;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [17:0] OFFSET_RST = 18'h00010;
  localparam int          ST_EMPTY_N = 0;
  localparam int          ST_AE_N    = 1;
  localparam int          ST_HF_N    = 2;
  localparam int          ST_AF_N    = 3;
  localparam int          ST_FULL_N  = 4;
  localparam int          ST_WR_TOK  = 5;
  localparam int          ST_RD_TOK  = 6;

  // ==========================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> rtl/dcf_axil.sv
// AXI4-Lite slave holding the control word and reaching the offset register.
// Assumes a master with at most one write and one read outstanding.
`timescale 1ns/1ps

module dcf_axil (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [dcf_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output wire logic                       s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output wire logic                       s_axi_wready,
  output wire logic [1:0]                 s_axi_bresp,
  output wire logic                       s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [dcf_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output wire logic                       s_axi_arready,
  output wire logic [31:0]                s_axi_rdata,
  output wire logic [1:0]                 s_axi_rresp,
  output wire logic                       s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output wire logic                       casc,
  output wire logic                       off_wr,
  output wire logic [17:0]                off_wdata,
  input  wire logic [17:0]                offset,
  input  wire logic [31:0]                status,
  input  wire logic [31:0]                level
);
  import dcf_pkg::*;

  logic              aw_got_r;
  logic              w_got_r;
  logic [AXI_AW-1:0] awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [1:0]        rresp_r;
  logic [31:0]       rdata_r;
  logic [31:0]       ctrl_r;
  logic              do_wr;
  logic [31:0]       off_merged;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  function automatic logic mapped(input logic [AXI_AW-1:0] a);
    mapped = ({a[AXI_AW-1:2], 2'b00} <= REG_LEVEL);
  endfunction

  // ==========================================================
  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_got_r;
  assign s_axi_wready  = !w_got_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign do_wr         = aw_got_r && w_got_r && !bvalid_r;
  assign off_merged    = merge({14'h0000, offset}, wdata_r, wstrb_r);
  assign off_wr        = do_wr && ({awaddr_r[AXI_AW-1:2], 2'b00} == REG_OFFSET);
  assign off_wdata     = off_merged[17:0];
  assign casc          = ctrl_r[CTRL_CASC];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= '0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_got_r) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_got_r) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
    end else if (do_wr && ({awaddr_r[AXI_AW-1:2], 2'b00} == REG_CTRL)) begin
      ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r) & 32'h0000_0001;
    end
  end

  // ==========================================================
  // Read channel: one read at a time, data registered
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rresp_r  <= RESP_OKAY;
      if ({s_axi_araddr[AXI_AW-1:2], 2'b00} == REG_CTRL) begin
        rdata_r <= ctrl_r;
      end else if ({s_axi_araddr[AXI_AW-1:2], 2'b00} == REG_OFFSET) begin
        rdata_r <= {14'h0000, offset};
      end else if ({s_axi_araddr[AXI_AW-1:2], 2'b00} == REG_STATUS) begin
        rdata_r <= status;
      end else if ({s_axi_araddr[AXI_AW-1:2], 2'b00} == REG_LEVEL) begin
        rdata_r <= level;
      end else begin
        rdata_r <= 32'h0000_0000;
        rresp_r <= RESP_SLVERR;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule

// >>> testbench/dcf_peer.sv
// Partner model: the writer and reader clocks, handed to the FIFO as tick enables.
// Assumes the bench owns reset, the enables and the data.
`timescale 1ns/1ps

// ==========================================================
// Tick source
module dcf_peer (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic slow,
  output logic      wr_tick,
  output logic      rd_tick
);
  logic [1:0] wc_r;
  logic       rc_r;

  // No edges in reset, so nothing is read or written before it ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wc_r    <= 2'h0;
      rc_r    <= 1'b0;
      wr_tick <= 1'b0;
      rd_tick <= 1'b0;
    end else begin
      // Slow: write every third cycle, read every second, rates unrelated
      wc_r    <= (wc_r == 2'h2) ? 2'h0 : wc_r + 2'h1;
      rc_r    <= ~rc_r;
      wr_tick <= slow ? (wc_r == 2'h2) : 1'b1;
      rd_tick <= slow ? rc_r : 1'b1;
    end
  end
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the flagged FIFO, depth 16, with its register slave.
// Assumes dcf_peer supplies the write and read ticks.
`timescale 1ns/1ps

module tb_top;
  import dcf_pkg::*;
  // ==========================================================
  // Signals
  logic aclk = 1'b0, aresetn, reset_n, slow, wr_en_n, rd_en_n, output_en_n;
  logic offset_load_n, flag_sync_mode_n, replay_strobe, chain_first_n;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [17:0] wr_data, rd_data;
  logic rd_data_oe, write_chain_out_half_full_n, read_chain_out_n, empty_n, full_n;
  logic almost_empty_n, almost_full_n, wr_tick, rd_tick;
  logic [4:0] flg;
  int n_fail = 0;
  int num_checks = 0;
  assign flg = {empty_n, almost_empty_n, write_chain_out_half_full_n, almost_full_n, full_n};
  always #2 aclk = ~aclk;

  dcf_peer peer (.aclk, .aresetn, .slow, .wr_tick, .rd_tick);
  // Ring of one device closes on itself
  dcf_fifo #(.DEPTH(16)) dut (.aclk, .aresetn, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wr_tick, .wr_en_n, .wr_data, .rd_tick,
    .rd_en_n, .rd_data, .rd_data_oe, .output_en_n, .offset_load_n, .flag_sync_mode_n,
    .replay_strobe, .chain_first_n, .write_chain_in_n(write_chain_out_half_full_n),
    .read_chain_in_n(read_chain_out_n), .write_chain_out_half_full_n, .read_chain_out_n,
    .empty_n, .full_n, .almost_empty_n, .almost_full_n);

  // ==========================================================
  // Helpers
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // No cycle count assumed: only the watchdog ends a stuck wait
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask

  task axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  // Writes n words base, base+1, ... one per write tick
  task wr_n(input int n, input logic [17:0] b);
    int c;
    c = 0;
    wr_data <= b;
    wr_en_n <= 1'b0;
    while (c < n) begin
      @(posedge aclk);
      if (wr_tick) begin
        c++;
        wr_data <= b + 18'(c);
        if (c == n) wr_en_n <= 1'b1;
      end
    end
  endtask

  // Reads n words, each judged one cycle after its read edge
  task rd_n(input int n, input logic [17:0] e0, input logic [17:0] st);
    int c;
    logic pend;
    logic [17:0] e;
    c = 0;
    pend = 1'b0;
    e = e0;
    rd_en_n <= 1'b0;
    while (c < n || pend) begin
      @(posedge aclk);
      if (pend) begin
        chk(32'(rd_data), 32'(e));
        e = e + st;
      end
      pend = rd_tick && c < n;
      if (pend) c++;
      if (pend && c == n) rd_en_n <= 1'b1;
    end
  endtask

  // Flags follow ticks, so let two of each pass
  task settle;
    int w, r;
    w = 0;
    r = 0;
    while (w < 2 || r < 2) begin
      @(posedge aclk);
      w += int'(wr_tick);
      r += int'(rd_tick);
    end
  endtask

  // ==========================================================
  // Scenarios
  task t_regs;
    logic [31:0] d;
    logic [1:0] r;
    chk(32'(flg), 32'h07);
    chk(32'(rd_data), 32'h0);
    axi_rd(REG_OFFSET, d, r);
    chk(d, 32'(OFFSET_RST));
    axi_rd(5'h10, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    axi_wr(5'h14, 32'h1, r);
    chk(32'(r), 32'(RESP_SLVERR));
    axi_wr(REG_OFFSET, 32'h4, r);
    offset_load_n <= 1'b0;
    wr_n(1, 18'h3);
    offset_load_n <= 1'b1;
    axi_rd(REG_OFFSET, d, r);
    chk(d, 32'h3);
    offset_load_n <= 1'b0;
    rd_n(1, 18'h3, 18'h0);
    offset_load_n <= 1'b1;
  endtask

  task t_fill;
    logic [31:0] d;
    logic [1:0] r;
    slow <= 1'b1;
    flag_sync_mode_n <= 1'b0;
    wr_n(8, 18'h2A000);
    settle;
    chk(32'(flg), 32'h1F);
    // Ninth word crosses half; the seventeenth finds the buffer full
    wr_n(9, 18'h2A008);
    settle;
    chk(32'(flg), 32'h18);
    axi_rd(REG_LEVEL, d, r);
    chk(d, 32'd16);
  endtask

  task t_drain;
    slow <= 1'b0;
    flag_sync_mode_n <= 1'b1;
    rd_n(16, 18'h2A000, 18'h1);
    rd_n(1, 18'h2A00F, 18'h0);
    settle;
    chk(32'(flg), 32'h07);
    output_en_n <= 1'b1;
    @(posedge aclk);
    chk(32'(rd_data_oe), 32'h0);
    output_en_n <= 1'b0;
    @(posedge aclk);
    chk(32'(rd_data_oe), 32'h1);
  endtask

  task t_midreset;
    logic [31:0] d;
    logic [1:0] r;
    wr_n(3, 18'h15555);
    settle;
    // Replay rewinds the read side, so the first word comes out again
    rd_n(1, 18'h15555, 18'h0);
    replay_strobe <= 1'b1;
    @(posedge aclk);
    replay_strobe <= 1'b0;
    rd_n(2, 18'h15555, 18'h1);
    reset_n <= 1'b0;
    repeat (2) @(posedge aclk);
    reset_n <= 1'b1;
    @(posedge aclk);
    chk(32'(flg), 32'h07);
    axi_rd(REG_LEVEL, d, r);
    chk(d, 32'h0);
  endtask

  // Cascade on a ring of one: each token leaves and comes straight back
  task t_casc;
    logic [31:0] d;
    logic [1:0] r;
    axi_wr(REG_CTRL, 32'h1, r);
    wr_n(16, 18'h0);
    @(posedge aclk);
    chk(32'(write_chain_out_half_full_n), 32'h0);
    axi_rd(REG_STATUS, d, r);
    chk(32'(d[ST_RD_TOK:ST_FULL_N]), 32'h6);
    rd_n(16, 18'h0, 18'h1);
    chk(32'(read_chain_out_n), 32'h0);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    {aresetn, reset_n, slow, flag_sync_mode_n, replay_strobe} = 5'b00010;
    {wr_en_n, rd_en_n, output_en_n, offset_load_n, chain_first_n} = 5'b11010;
    // Responses are always taken as soon as they are offered
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h05;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, wr_data} = '0;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    reset_n <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_fill;
    t_drain;
    t_midreset;
    t_casc;
    test_done;
  end

  initial begin
    #100000;
    n_fail++;
    test_done;
  end
endmodule
